// ---- cpualu_map.svh ----
// Summary of operation
// - subtract writes dst plus inverted src plus one; src untouched.
// - subtract-with-borrow writes dst plus inverted src plus carry; src untouched.
// - after subtract, carry is carry out of msb: 1 no borrow.
// - subtract sets N, Z, and V on signed overflow, clears otherwise.
// - these operations never change oscillator, core halt or interrupt allow bits.
// - byte exchange swaps high and low bytes of destination.
// - sign widen copies bit 7 into bits 8 through 15.
// - sign widen sets N, Z from result, carry not zero, V cleared.
// - zero compare evaluates dst plus all-ones plus one, no write, C=1, V=0.
// - exclusive-or writes src xor dst; N from msb, Z on zero.
// - exclusive-or carry is not zero; V when both operands negative.
// - cycle count depends only on format and addressing modes.
// - interrupt return 5 cycles 1 word, accept 6, both resets 4.
// - single operand register 1/3/4, indirect 3/4/4, autoincrement 3/5/5; 1 word.
// - immediate push 4, call 5; indexed modes shift 4, push/call 5; 2 words.
// - immediate mode for shift, swap, extend is undefined.
// - every jump takes one word and two cycles, taken or not.
// - double operand register, indirect, autoincrement source timings and lengths.
// - double operand immediate and indexed source timings and lengths.
`ifndef CPUALU_MAP_SVH
`define CPUALU_MAP_SVH
`define CPUALU_REG_SR 4'h0
`define CPUALU_REG_RESULT 4'h1
`define CPUALU_REG_TIMING 4'h2
`define CPUALU_REG_STATE 4'h3
`define CPUALU_SR_C 0
`define CPUALU_SR_Z 1
`define CPUALU_SR_N 2
`define CPUALU_SR_GIE 3
`define CPUALU_SR_CORE_HALT_BIT 4
`define CPUALU_SR_OSCILLATOR_HALT_BIT 5
`define CPUALU_SR_V 8
`define CPUALU_SR_MASK 16'h013F
`define CPUALU_SR_RST 16'h0000
// rows: words mem,pc,reg then cycles mem,pc,reg
`define CPUALU_DBL_REG 24'h211421
`define CPUALU_DBL_IND 24'h211522
`define CPUALU_DBL_AUTO 24'h211532
`define CPUALU_DBL_IMM 24'h322532
`define CPUALU_DBL_IDX 24'h322633
// rows: words, call, push, shift cycles
`define CPUALU_SGL_REG 16'h1431
`define CPUALU_SGL_IND 16'h1443
`define CPUALU_SGL_AUTO 16'h1553
`define CPUALU_SGL_IMM 16'h2544
`define CPUALU_SGL_IDX 16'h2554
`define CPUALU_JMP_CYC 4'h2
`define CPUALU_JMP_WORDS 4'h1
`define CPUALU_INTERRUPT_RETURN_OP_CYC 4'h5
`define CPUALU_INTERRUPT_RETURN_OP_WORDS 4'h1
`define CPUALU_IRQ_CYC 4'h6
`define CPUALU_IRQ_WORDS 4'h0
`define CPUALU_RST_CYC 4'h4
`endif

// ---- cpualu_pkg.sv ----
package cpualu_pkg;
  typedef enum logic [2:0] {FMT_DOUBLE, FMT_SHIFT, FMT_PUSH, FMT_CALL, FMT_JUMP, FMT_INTERRUPT_RETURN_OP, FMT_IRQ} cpualu_fmt_t;
  typedef enum logic [2:0] {OP_NONE, OP_SUB, OP_MINUS_WITH_BORROW_OP, OP_BYTE_EXCHANGE_OP, OP_SXT, OP_TST, OP_XOR} cpualu_op_t;
  typedef enum logic [2:0] {AM_REG, AM_IND, AM_AUTO, AM_IMM, AM_IDX, AM_SYM, AM_ABS} cpualu_mode_t;
  typedef enum logic [1:0] {DK_REG, DK_PC, DK_MEM} cpualu_dkind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RST} cpualu_fsm_t;
  typedef struct packed {
    cpualu_fmt_t fmt;
    cpualu_op_t op;
    logic byte_op;
    cpualu_mode_t smode;
    cpualu_dkind_t dkind;
    logic [15:0] src;
    logic [15:0] dst;
  } cpualu_req_t;
  typedef struct packed {
    logic [15:0] res;
    logic n;
    logic z;
    logic c;
    logic v;
    logic wr;
    logic upd;
  } cpualu_alu_t;
  typedef struct packed {
    logic [3:0] cyc;
    logic [3:0] words;
  } cpualu_time_t;
  typedef struct packed {
    cpualu_fsm_t fsm;
    logic [3:0] cnt;
    logic [15:0] sr;
    logic [15:0] result;
    logic wr;
    cpualu_time_t tim;
    logic undef;
    logic [15:0] rdata;
  } cpualu_state_t;
endpackage

// ---- cpualu_core.sv ----
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "cpualu_map.svh"
module cpualu_core (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic wdog_rst_i,
  input wire logic req_valid_i,
  input wire cpualu_pkg::cpualu_req_t req_i,
  output logic ready_o,
  output logic done_o,
  output logic dst_write_o,
  output logic [15:0] result_o,
  output logic [3:0] cycles_o,
  output logic [3:0] words_o,
  output logic undef_o,
  output logic [15:0] sr_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o
);

  // ---------------------------------------------
  // datapath
  // ---------------------------------------------
  function automatic cpualu_pkg::cpualu_alu_t alu_eval(
    input cpualu_pkg::cpualu_req_t q,
    input logic cin
  );
    cpualu_pkg::cpualu_alu_t a;
    logic [15:0] s;
    logic [15:0] d;
    logic [16:0] sw;
    logic [8:0] sb;
    logic ci;
    logic b8;
    logic ms;
    logic md;
    logic mr;
    a = '0;
    mr = 1'b0;
    s = q.src;
    d = q.dst;
    ci = 1'b1;
    b8 = q.byte_op && q.op != cpualu_pkg::OP_BYTE_EXCHANGE_OP && q.op != cpualu_pkg::OP_SXT;
    if (b8) begin
      s = {8'h00, s[7:0]};
      d = {8'h00, d[7:0]};
    end
    if (q.op == cpualu_pkg::OP_TST) begin
      s = 16'h0000;
    end
    if (q.op == cpualu_pkg::OP_MINUS_WITH_BORROW_OP) begin
      ci = cin;
    end
    sw = {1'b0, d} + {1'b0, ~s} + {16'h0000, ci};
    sb = {1'b0, d[7:0]} + {1'b0, ~s[7:0]} + {8'h00, ci};
    ms = b8 ? s[7] : s[15];
    md = b8 ? d[7] : d[15];
    unique case (q.op)
      cpualu_pkg::OP_NONE: begin
        a.res = q.dst;
      end
      cpualu_pkg::OP_SUB, cpualu_pkg::OP_MINUS_WITH_BORROW_OP, cpualu_pkg::OP_TST: begin
        a.res = b8 ? {8'h00, sb[7:0]} : sw[15:0];
        a.c = b8 ? sb[8] : sw[16];
        mr = b8 ? sb[7] : sw[15];
        a.v = (md != ms) && (mr != md);
        a.wr = q.op != cpualu_pkg::OP_TST;
        a.upd = 1'b1;
      end
      cpualu_pkg::OP_BYTE_EXCHANGE_OP: begin
        a.res = {q.dst[7:0], q.dst[15:8]};
        a.wr = 1'b1;
      end
      cpualu_pkg::OP_SXT: begin
        a.res = {{8{q.dst[7]}}, q.dst[7:0]};
        a.wr = 1'b1;
        a.upd = 1'b1;
      end
      cpualu_pkg::OP_XOR: begin
        a.res = s ^ d;
        a.v = ms && md;
        a.wr = 1'b1;
        a.upd = 1'b1;
      end
    endcase
    a.n = b8 ? a.res[7] : a.res[15];
    a.z = b8 ? (a.res[7:0] == 8'h00) : (a.res == 16'h0000);
    if (q.op == cpualu_pkg::OP_XOR || q.op == cpualu_pkg::OP_SXT) begin
      a.c = !a.z;
    end
    if (q.op == cpualu_pkg::OP_TST) begin
      a.c = 1'b1;
      a.v = 1'b0;
    end
    return a;
  endfunction

  // ---------------------------------------------
  // cycle and length tables
  // ---------------------------------------------
  function automatic cpualu_pkg::cpualu_time_t time_eval(
    input cpualu_pkg::cpualu_req_t q
  );
    cpualu_pkg::cpualu_time_t t;
    logic [23:0] drow;
    logic [15:0] srow;
    logic [3:0] dc;
    logic [3:0] dw;
    t = '0;
    drow = `CPUALU_DBL_IDX;
    srow = `CPUALU_SGL_IDX;
    unique case (q.smode)
      cpualu_pkg::AM_REG: begin
        drow = `CPUALU_DBL_REG;
        srow = `CPUALU_SGL_REG;
      end
      cpualu_pkg::AM_IND: begin
        drow = `CPUALU_DBL_IND;
        srow = `CPUALU_SGL_IND;
      end
      cpualu_pkg::AM_AUTO: begin
        drow = `CPUALU_DBL_AUTO;
        srow = `CPUALU_SGL_AUTO;
      end
      cpualu_pkg::AM_IMM: begin
        drow = `CPUALU_DBL_IMM;
        srow = `CPUALU_SGL_IMM;
      end
      cpualu_pkg::AM_IDX, cpualu_pkg::AM_SYM, cpualu_pkg::AM_ABS: begin
        drow = `CPUALU_DBL_IDX;
        srow = `CPUALU_SGL_IDX;
      end
    endcase
    unique case (q.dkind)
      cpualu_pkg::DK_REG: begin
        dc = drow[3:0];
        dw = drow[15:12];
      end
      cpualu_pkg::DK_PC: begin
        dc = drow[7:4];
        dw = drow[19:16];
      end
      default: begin
        dc = drow[11:8];
        dw = drow[23:20];
      end
    endcase
    // depends on format and modes only, never on the operation
    unique case (q.fmt)
      cpualu_pkg::FMT_DOUBLE: begin
        t.cyc = dc;
        t.words = dw;
      end
      cpualu_pkg::FMT_SHIFT: begin
        t.cyc = srow[3:0];
        t.words = srow[15:12];
      end
      cpualu_pkg::FMT_PUSH: begin
        t.cyc = srow[7:4];
        t.words = srow[15:12];
      end
      cpualu_pkg::FMT_CALL: begin
        t.cyc = srow[11:8];
        t.words = srow[15:12];
      end
      cpualu_pkg::FMT_JUMP: begin
        t.cyc = `CPUALU_JMP_CYC;
        t.words = `CPUALU_JMP_WORDS;
      end
      cpualu_pkg::FMT_INTERRUPT_RETURN_OP: begin
        t.cyc = `CPUALU_INTERRUPT_RETURN_OP_CYC;
        t.words = `CPUALU_INTERRUPT_RETURN_OP_WORDS;
      end
      cpualu_pkg::FMT_IRQ: begin
        t.cyc = `CPUALU_IRQ_CYC;
        t.words = `CPUALU_IRQ_WORDS;
      end
    endcase
    return t;
  endfunction

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  cpualu_pkg::cpualu_state_t s_reg;
  cpualu_pkg::cpualu_state_t s_next;
  cpualu_pkg::cpualu_alu_t alu;
  cpualu_pkg::cpualu_time_t tim;
  logic last;
  logic take;

  assign alu = alu_eval(req_i, s_reg.sr[`CPUALU_SR_C]);
  assign tim = time_eval(req_i);
  assign last = s_reg.cnt == 4'h1;
  assign ready_o = s_reg.fsm == cpualu_pkg::ST_IDLE || (s_reg.fsm == cpualu_pkg::ST_RUN && last);
  assign done_o = s_reg.fsm == cpualu_pkg::ST_RUN && last;
  assign take = ready_o && req_valid_i;
  assign dst_write_o = done_o && s_reg.wr;
  assign result_o = s_reg.result;
  assign cycles_o = s_reg.tim.cyc;
  assign words_o = s_reg.tim.words;
  assign undef_o = s_reg.undef;
  assign sr_o = s_reg.sr;
  assign reg_rdata_o = s_reg.rdata;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 16'h0000;
    if (reg_wr_i && reg_addr_i == `CPUALU_REG_SR) begin
      s_next.sr = reg_wdata_i & `CPUALU_SR_MASK;
    end
    unique case (s_reg.fsm)
      cpualu_pkg::ST_IDLE: begin
      end
      cpualu_pkg::ST_RUN, cpualu_pkg::ST_RST: begin
        if (last) begin
          s_next.fsm = cpualu_pkg::ST_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
    endcase
    if (take) begin
      s_next.fsm = cpualu_pkg::ST_RUN;
      s_next.cnt = tim.cyc;
      s_next.tim = tim;
      s_next.result = alu.res;
      s_next.wr = alu.wr;
      s_next.undef = req_i.fmt == cpualu_pkg::FMT_SHIFT && req_i.smode == cpualu_pkg::AM_IMM;
      if (alu.upd) begin
        // flag update wins over a software write in the same cycle; mode bits untouched
        s_next.sr[`CPUALU_SR_C] = alu.c;
        s_next.sr[`CPUALU_SR_Z] = alu.z;
        s_next.sr[`CPUALU_SR_N] = alu.n;
        s_next.sr[`CPUALU_SR_V] = alu.v;
      end
      if (req_i.fmt == cpualu_pkg::FMT_INTERRUPT_RETURN_OP) begin
        s_next.sr = req_i.src & `CPUALU_SR_MASK;
      end
    end
    if (wdog_rst_i) begin
      s_next.fsm = cpualu_pkg::ST_RST;
      s_next.cnt = `CPUALU_RST_CYC;
      s_next.sr = `CPUALU_SR_RST;
      s_next.wr = 1'b0;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `CPUALU_REG_SR: s_next.rdata = s_reg.sr;
        `CPUALU_REG_RESULT: s_next.rdata = s_reg.result;
        `CPUALU_REG_TIMING: s_next.rdata = {8'h00, s_reg.tim.words, s_reg.tim.cyc};
        `CPUALU_REG_STATE: s_next.rdata = {13'h0000, s_reg.undef, ready_o, s_reg.fsm == cpualu_pkg::ST_RST};
        default: s_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{fsm: cpualu_pkg::ST_RST, cnt: `CPUALU_RST_CYC, sr: `CPUALU_SR_RST, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic tk_ok;
  assign tk_ok = take && !wdog_rst_i;

  sequence s_jump_take;
    tk_ok && req_i.fmt == cpualu_pkg::FMT_JUMP;
  endsequence
  sequence s_interrupt_return_op_take;
    tk_ok && req_i.fmt == cpualu_pkg::FMT_INTERRUPT_RETURN_OP;
  endsequence
  sequence s_irq_take;
    tk_ok && req_i.fmt == cpualu_pkg::FMT_IRQ;
  endsequence
  sequence s_quiet;
    !wdog_rst_i && !req_valid_i;
  endsequence

  sub_result_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_SUB && !req_i.byte_op
    |=> result_o == 16'($past(req_i.dst) - $past(req_i.src)) && s_reg.wr)
    else $error("subtract result wrong");

  sub_carry_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_SUB && !req_i.byte_op && !reg_wr_i
    |=> sr_o[`CPUALU_SR_C] == ($past(req_i.dst) >= $past(req_i.src)))
    else $error("subtract carry wrong");

  minus_with_borrow_op_result_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_MINUS_WITH_BORROW_OP && !req_i.byte_op
    |=> result_o == 16'($past(req_i.dst) + ~$past(req_i.src) + {15'h0000, $past(sr_o[`CPUALU_SR_C])}))
    else $error("borrow subtract result wrong");

  mode_bits_a: assert property (
    tk_ok && !reg_wr_i && req_i.fmt != cpualu_pkg::FMT_INTERRUPT_RETURN_OP
    |=> $stable(sr_o[`CPUALU_SR_OSCILLATOR_HALT_BIT:`CPUALU_SR_GIE]))
    else $error("mode bits changed");

  swap_bytes_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_BYTE_EXCHANGE_OP
    |=> result_o == {$past(req_i.dst[7:0]), $past(req_i.dst[15:8])})
    else $error("byte exchange wrong");

  sign_widen_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_SXT && !reg_wr_i
    |=> result_o[15:8] == {8{$past(req_i.dst[7])}} && sr_o[`CPUALU_SR_C] == (result_o != 16'h0000)
    && !sr_o[`CPUALU_SR_V])
    else $error("sign widen wrong");

  zero_cmp_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_TST && !reg_wr_i
    |=> !s_reg.wr && sr_o[`CPUALU_SR_C] && !sr_o[`CPUALU_SR_V]
    && sr_o[`CPUALU_SR_Z] == ($past(req_i.byte_op) ? ($past(req_i.dst[7:0]) == 8'h00)
    : ($past(req_i.dst) == 16'h0000)))
    else $error("zero compare wrong");

  xor_flags_a: assert property (
    tk_ok && req_i.op == cpualu_pkg::OP_XOR && !req_i.byte_op && !reg_wr_i
    |=> sr_o[`CPUALU_SR_V] == ($past(req_i.src[15]) && $past(req_i.dst[15]))
    && result_o == ($past(req_i.src) ^ $past(req_i.dst)))
    else $error("exclusive or wrong");

  jump_time_a: assert property (
    s_jump_take ##1 s_quiet |-> !done_o ##1 done_o)
    else $error("jump timing wrong");

  interrupt_return_op_time_a: assert property (
    s_interrupt_return_op_take ##1 s_quiet[*5] |-> done_o && words_o == 4'h1 && $past(!done_o, 1) && $past(!done_o, 4))
    else $error("interrupt return timing wrong");

  irq_time_a: assert property (
    disable iff (!arst_n_i || wdog_rst_i) s_irq_take |=> !done_o[*5] ##1 done_o)
    else $error("interrupt accept timing wrong");

  wdog_time_a: assert property (
    wdog_rst_i ##1 !wdog_rst_i[*4] |-> $past(!ready_o, 3) && !ready_o ##1 ready_o)
    else $error("reset sequence timing wrong");

  reg_mem_time_a: assert property (
    tk_ok && req_i.fmt == cpualu_pkg::FMT_DOUBLE && req_i.smode == cpualu_pkg::AM_REG
    && req_i.dkind == cpualu_pkg::DK_MEM
    |=> words_o == 4'h2 && cycles_o == 4'h4)
    else $error("register to memory timing wrong");

  idx_mem_time_a: assert property (
    tk_ok && req_i.fmt == cpualu_pkg::FMT_DOUBLE && req_i.smode == cpualu_pkg::AM_IDX
    && req_i.dkind == cpualu_pkg::DK_MEM
    |=> words_o == 4'h3 && cycles_o == 4'h6)
    else $error("indexed to memory timing wrong");

  single_reg_a: assert property (
    tk_ok && req_i.fmt == cpualu_pkg::FMT_SHIFT && req_i.smode == cpualu_pkg::AM_REG
    |=> done_o)
    else $error("single register timing wrong");

  call_imm_a: assert property (
    tk_ok && req_i.fmt == cpualu_pkg::FMT_CALL && req_i.smode == cpualu_pkg::AM_IMM
    |=> cycles_o == 4'h5 && words_o == 4'h2)
    else $error("immediate call timing wrong");

endmodule

// ---- cpualu_prog_mem.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// instruction source on the fetch side
// ----------------------------------------
// offers one decoded word per load and holds it until taken; the bench
// decides how soon the next load comes, so answers may be prompt or slow
module cpualu_prog_mem (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire cpualu_pkg::cpualu_req_t word_i,
  input wire logic ready_i,
  output logic valid_o,
  output cpualu_pkg::cpualu_req_t req_o
);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_o <= 1'b0;
      req_o <= '0;
    end else if (load_i) begin
      valid_o <= 1'b1;
      req_o <= word_i;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      // released bus shows the last word inverted
      req_o <= ~req_o;
    end
  end
endmodule

// ---- cpualu_tb.sv ----
`timescale 1ns/10ps
module tb;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wdog_rst_i = 1'b0;
  logic load = 1'b0;
  cpualu_pkg::cpualu_req_t word = '0;
  cpualu_pkg::cpualu_req_t req_i;
  logic req_valid_i, ready_o, done_o, dst_write_o, undef_o;
  logic [15:0] result_o, sr_o, reg_rdata_o;
  logic [3:0] cycles_o, words_o;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  int bad_count = 0;
  int n_compared = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  cpualu_prog_mem cpualu_prog_mem_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .load_i(load), .word_i(word),
    .ready_i(ready_o), .valid_o(req_valid_i), .req_o(req_i));
  cpualu_core cpualu_core_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .wdog_rst_i(wdog_rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o), .done_o(done_o), .dst_write_o(dst_write_o),
    .result_o(result_o), .cycles_o(cycles_o), .words_o(words_o), .undef_o(undef_o), .sr_o(sr_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic cpualu_pkg::cpualu_req_t mk(input logic [2:0] f, input logic [2:0] o, input logic b,
    input logic [2:0] m, input logic [1:0] d, input logic [15:0] s, input logic [15:0] t);
    mk = {f, o, b, m, d, s, t};
  endfunction

  task automatic run(input cpualu_pkg::cpualu_req_t r, input logic [15:0] er, input logic [3:0] ef,
    input logic ew, input logic [3:0] ec, input logic [3:0] ewd, input logic full);
    int n;
    @(posedge ref_clk_i);
    load <= 1'b1;
    word <= r;
    @(posedge ref_clk_i);
    load <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (!(ready_o === 1'b1 && req_valid_i === 1'b1) && n < 20);
    @(posedge ref_clk_i);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 12);
    chk(16'(n), 16'(ec));
    chk({cycles_o, words_o}, {ec, ewd});
    if (full) begin
      chk(result_o, er);
      chk({12'h000, sr_o[8], sr_o[2], sr_o[1], sr_o[0]}, {12'h000, ef});
      chk({15'h0000, dst_write_o}, {15'h0000, ew});
    end
  endtask

  task automatic dbl(input logic [2:0] o, input logic b, input logic [15:0] s, input logic [15:0] t,
    input logic [15:0] er, input logic [3:0] ef);
    run(mk(3'h0, o, b, 3'h0, 2'h0, s, t), er, ef, 1'b1, 4'h1, 4'h1, 1'b1);
  endtask

  task automatic sgl(input logic [2:0] o, input logic [15:0] t, input logic [15:0] er, input logic [3:0] ef);
    run(mk(3'h1, o, 1'b0, 3'h0, 2'h0, 16'h0000, t), er, ef, 1'b1, 4'h1, 4'h1, 1'b1);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(reg_rdata_o, e);
  endtask

  task automatic rst_seq;
    repeat (4) begin
      @(negedge ref_clk_i);
      chk({14'h0000, ready_o, done_o}, 16'h0000);
    end
    @(negedge ref_clk_i);
    chk({14'h0000, ready_o, done_o}, 16'h0002);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    reg_wr(4'h0, 16'h0038);
    dbl(cpualu_pkg::OP_SUB, 1'b0, 16'h0007, 16'h0005, 16'hFFFE, 4'b0100);
    reg_rd(4'h0, 16'h003C);
    reg_wr(4'h1, 16'h1234);
    reg_rd(4'h1, 16'hFFFE);
    reg_rd(4'h2, 16'h0011);
    reg_rd(4'hF, 16'h0000);
    reg_wr(4'h0, 16'hFFFF);
    reg_rd(4'h0, 16'h013F);
  endtask

  task automatic t_sub;
    dbl(cpualu_pkg::OP_SUB, 1'b0, 16'h0001, 16'h8000, 16'h7FFF, 4'b1001);
    dbl(cpualu_pkg::OP_SUB, 1'b0, 16'h1234, 16'h1234, 16'h0000, 4'b0011);
    dbl(cpualu_pkg::OP_SUB, 1'b1, 16'h0001, 16'hAB80, 16'h007F, 4'b1001);
  endtask

  task automatic t_minus_with_borrow_op;
    dbl(cpualu_pkg::OP_MINUS_WITH_BORROW_OP, 1'b0, 16'h0001, 16'h0010, 16'h000F, 4'b0001);
    dbl(cpualu_pkg::OP_SUB, 1'b0, 16'h0001, 16'h0000, 16'hFFFF, 4'b0100);
    dbl(cpualu_pkg::OP_MINUS_WITH_BORROW_OP, 1'b0, 16'h0002, 16'h0005, 16'h0002, 4'b0001);
    dbl(cpualu_pkg::OP_MINUS_WITH_BORROW_OP, 1'b1, 16'h0001, 16'h0000, 16'h00FF, 4'b0100);
  endtask

  task automatic t_unary;
    sgl(cpualu_pkg::OP_SXT, 16'h0080, 16'hFF80, 4'b0101);
    sgl(cpualu_pkg::OP_SXT, 16'h7F00, 16'h0000, 4'b0010);
    sgl(cpualu_pkg::OP_BYTE_EXCHANGE_OP, 16'h40BF, 16'hBF40, 4'b0010);
    run(mk(3'h0, cpualu_pkg::OP_TST, 1'b0, 3'h3, 2'h0, 16'h0000, 16'h0000), 16'h0000, 4'b0011, 1'b0,
      4'h2, 4'h2, 1'b1);
    run(mk(3'h0, cpualu_pkg::OP_TST, 1'b1, 3'h3, 2'h0, 16'h0000, 16'h1280), 16'h0080, 4'b0101, 1'b0,
      4'h2, 4'h2, 1'b1);
    run(mk(3'h0, cpualu_pkg::OP_NONE, 1'b0, 3'h0, 2'h0, 16'h0000, 16'h5A5A), 16'h5A5A, 4'b0101, 1'b0,
      4'h1, 4'h1, 1'b1);
  endtask

  task automatic t_xor;
    dbl(cpualu_pkg::OP_XOR, 1'b0, 16'h8000, 16'h8001, 16'h0001, 4'b1001);
    dbl(cpualu_pkg::OP_XOR, 1'b1, 16'h34FF, 16'h12FF, 16'h0000, 4'b1010);
    dbl(cpualu_pkg::OP_XOR, 1'b0, 16'h0F0F, 16'hF0F0, 16'hFFFF, 4'b0101);
    chk({13'h0000, sr_o[5:3]}, 16'h0007);
  endtask

  task automatic t_timing;
    logic [15:0] rows [22] = '{16'h8021, 16'hA051, 16'hC060, 16'h4851, 16'h6C52, 16'h3042, 16'h2431,
      16'h4031, 16'h6041, 16'h4C42, 16'h3442, 16'h2C42, 16'h0121, 16'h0931, 16'h0242, 16'h0421,
      16'h0652, 16'h0D32, 16'h0E53, 16'h1263, 16'h1832, 16'h1532};
    cpualu_pkg::cpualu_req_t r;
    foreach (rows[i]) begin
      r = mk(rows[i][15:13], (i % 2 == 1) ? 3'h6 : 3'h1, 1'b0, rows[i][12:10], rows[i][9:8], 16'h0000,
        16'h0001);
      run(r, 16'h0000, 4'h0, 1'b0, rows[i][7:4], rows[i][3:0], 1'b0);
      chk({15'h0000, undef_o}, {15'h0000, rows[i] == 16'h2C42});
    end
  endtask

  task automatic t_wdog;
    reg_wr(4'h0, 16'h0038);
    @(posedge ref_clk_i);
    load <= 1'b1;
    word <= mk(3'h0, cpualu_pkg::OP_XOR, 1'b0, 3'h4, 2'h2, 16'h0001, 16'h0002);
    @(posedge ref_clk_i);
    load <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    wdog_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    wdog_rst_i <= 1'b0;
    rst_seq();
    chk(sr_o, 16'h0000);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rst_seq();
    chk(sr_o, 16'h0000);
    t_regs();
    t_sub();
    t_minus_with_borrow_op();
    t_unary();
    t_xor();
    t_timing();
    t_wdog();
    end_of_test();
  end

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule
